// [rtl/seq_top.sv]
/*
  Parameter-set sequencer: APB register file, active feature values, stored
  sets and the automatic branching between sets on trigger events.
  Assumes a single system clock; trigger events may be asynchronous.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Automatic switching runs only while the run control is on.
// - Turning run on first loads the set named by the initial index.
// - Current set index updates on every set load.
// - A path trigger firing moves to that path's target set.
// - With several paths, the first firing path wins; ties go to lowest path.
// - A load overwrites every member feature value at once.
// - Initial index accepts the same range as the set selector.
// - Number of sets equals the selector range; no separate count.
// - Member features are fixed by parameter and equal for all sets.
// - Store copies current member values into the selected set.
// - Recall copies the selected set into the active values.
// - Each set has several paths, each with trigger and target.
// - Path origin and edge act like the acquisition trigger choices.
// - All values of a set apply before the next frame starts.
// - Transitions need no software action once started.
// - All member features of a set take effect in the same cycle.
// - A load pulse and index let frames be tagged with their set.
// - Recall changes active values even while switching is off.
// - Edit mode is on/off and gates set editing.
module seq_top
  import seq_pkg::*;
#(
  parameter int                  NUM_SETS    = NUM_SETS_DEF,
  parameter int                  NUM_PATHS   = NUM_PATHS_DEF,
  parameter int                  NUM_FEAT    = NUM_FEAT_DEF,
  parameter int                  FEAT_W      = FEAT_W_DEF,
  parameter int                  NUM_EVT     = NUM_EVT_DEF,
  parameter logic [NUM_FEAT-1:0] MEMBER_MASK = '1
) (
  // Clock and reset
  input  wire logic                       I_SYS_CLK,
  input  wire logic                       I_SYS_RST,
  // APB slave
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [ADDR_W-1:0]          I_PADDR,
  input  wire logic [DATA_W-1:0]          I_PWDATA,
  input  wire logic [DATA_W/8-1:0]        I_PSTRB,
  output logic      [DATA_W-1:0]          O_PRDATA,
  output logic                            O_PREADY,
  output logic                            O_PSLVERR,
  // Trigger events
  input  wire logic [NUM_EVT-1:0]         I_TRIG_EVENTS,
  // Active settings and progress
  output logic      [NUM_FEAT*FEAT_W-1:0] O_FEAT_VAL,
  output logic      [$clog2(NUM_SETS)-1:0] O_CUR_SET,
  output logic                            O_RUNNING,
  output logic                            O_SET_LOADED
);

  localparam int SET_W  = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
  localparam int PATH_W = (NUM_PATHS > 1) ? $clog2(NUM_PATHS) : 1;
  localparam int FSEL_W = (NUM_FEAT > 1) ? $clog2(NUM_FEAT) : 1;

  typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;

  // ==========================================================================
  // Declarations
  seq_state_t                 state_q, state_d;
  logic                       run_q, run_d, edit_q, edit_d, loaded_q, loaded_d;
  logic [SET_W-1:0]           sel_q, sel_d, init_q, init_d, cur_q, cur_d;
  logic [PATH_W-1:0]          bsel_q, bsel_d;
  logic [FSEL_W-1:0]          fsel_q, fsel_d;
  logic [SET_W-1:0]           tgt_q [NUM_SETS][NUM_PATHS];
  logic [SET_W-1:0]           tgt_d [NUM_SETS][NUM_PATHS];
  logic [ORIGIN_W-1:0]        org_q [NUM_SETS][NUM_PATHS];
  logic [ORIGIN_W-1:0]        org_d [NUM_SETS][NUM_PATHS];
  trig_edge_t                 edg_q [NUM_SETS][NUM_PATHS];
  trig_edge_t                 edg_d [NUM_SETS][NUM_PATHS];
  logic [NUM_FEAT*FEAT_W-1:0] act_q, act_d, bank_rd;
  logic [DATA_W-1:0]          prdata_q, prdata_d, rd_word, wmerged;
  logic                       addr_ok, wr_en, store_go, recall_go;
  logic                       load_go;
  logic [SET_W-1:0]           load_set;
  logic [NUM_EVT-1:0]         ev_rise, ev_fall, ev_lvl;
  logic [NUM_PATHS-1:0]       hit;
  logic                       any_hit;
  logic [PATH_W-1:0]          win_idx;
  logic [SET_W-1:0]           win_tgt;

  // ==========================================================================
  // Byte-lane merge of a write into the current register value
  function automatic logic [DATA_W-1:0] merge_f(input logic [DATA_W-1:0]   old,
                                                input logic [DATA_W-1:0]   wd,
                                                input logic [DATA_W/8-1:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < DATA_W/8; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Trigger test, same meaning as the acquisition trigger origin and edge
  function automatic logic hit_f(input logic [ORIGIN_W-1:0] org,
                                 input trig_edge_t          edg,
                                 input logic [NUM_EVT-1:0]  rise,
                                 input logic [NUM_EVT-1:0]  fall,
                                 input logic [NUM_EVT-1:0]  lvl);
    logic h;
    h = 1'b0;
    for (int i = 0; i < NUM_EVT; i++) begin
      if (org == ORIGIN_W'(i + 1)) begin
        unique case (edg)
          EDGE_RISE: h = rise[i];
          EDGE_FALL: h = fall[i];
          EDGE_ANY:  h = rise[i] | fall[i];
          EDGE_HIGH: h = lvl[i];
        endcase
      end
    end
    return h;
  endfunction

  // ==========================================================================
  // Submodules
  trig_sense #(.NUM_EVT(NUM_EVT)) u_sense (
    .i_clk  (I_SYS_CLK),
    .i_rst  (I_SYS_RST),
    .i_evt  (I_TRIG_EVENTS),
    .o_rise (ev_rise),
    .o_fall (ev_fall),
    .o_lvl  (ev_lvl)
  );

  set_bank #(
    .NUM_SETS (NUM_SETS),
    .NUM_FEAT (NUM_FEAT),
    .FEAT_W   (FEAT_W),
    .SET_W    (SET_W)
  ) u_bank (
    .i_clk     (I_SYS_CLK),
    .i_rst     (I_SYS_RST),
    .i_wr      (store_go),
    .i_wr_set  (sel_q),
    .i_wr_mask (MEMBER_MASK),
    .i_wr_data (act_q),
    .i_rd_set  (load_set),
    .o_rd_data (bank_rd)
  );

  // ==========================================================================
  // APB decode and readback; unmapped or unaligned addresses give PSLVERR
  always_comb begin
    addr_ok = 1'b1;
    rd_word = '0;
    unique case (I_PADDR)
      ADDR_CTRL: begin
        rd_word[CTRL_RUN_BIT]  = run_q;
        rd_word[CTRL_EDIT_BIT] = edit_q;
      end
      ADDR_SET_SEL:    rd_word[SET_W-1:0]  = sel_q;
      ADDR_INIT_SET:   rd_word[SET_W-1:0]  = init_q;
      ADDR_CMD:        rd_word = '0;
      ADDR_STATUS: begin
        rd_word[SET_W-1:0]   = cur_q;
        rd_word[STAT_RUN_BIT] = (state_q == ST_RUN);
      end
      ADDR_BRANCH_SEL: rd_word[PATH_W-1:0] = bsel_q;
      ADDR_BRANCH_CFG: begin
        rd_word[CFG_TGT_LSB +: SET_W]     = tgt_q[sel_q][bsel_q];
        rd_word[CFG_ORG_LSB +: ORIGIN_W]  = org_q[sel_q][bsel_q];
        rd_word[CFG_EDGE_LSB +: 2]        = edg_q[sel_q][bsel_q];
      end
      ADDR_FEAT_SEL:   rd_word[FSEL_W-1:0] = fsel_q;
      ADDR_FEAT_ON:    rd_word[0]          = MEMBER_MASK[fsel_q];
      ADDR_FEAT_VAL:   rd_word[FEAT_W-1:0] = act_q[fsel_q*FEAT_W +: FEAT_W];
      default:         addr_ok = 1'b0;
    endcase
    wmerged = merge_f(rd_word, I_PWDATA, I_PSTRB);
  end

  assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE & addr_ok;
  assign store_go  = wr_en && (I_PADDR == ADDR_CMD) && wmerged[CMD_STORE_BIT] && edit_q;
  assign recall_go = wr_en && (I_PADDR == ADDR_CMD) && wmerged[CMD_RECALL_BIT];

  // Read data captured in the setup cycle, so the slave needs no wait state
  always_comb begin
    prdata_d = prdata_q;
    if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      prdata_d = rd_word;
    end
  end

  // ==========================================================================
  // Path evaluation for the active set
  // per path trigger test
  for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
    assign hit[p] = (org_q[cur_q][p] != ORIGIN_OFF) &&
                    hit_f(org_q[cur_q][p], edg_q[cur_q][p], ev_rise, ev_fall, ev_lvl);
  end

  always_comb begin
    win_idx = '0;
    for (int p = NUM_PATHS - 1; p >= 0; p--) begin
      if (hit[p]) begin
        win_idx = PATH_W'(p);
      end
    end
    any_hit = |hit;
    win_tgt = tgt_q[cur_q][win_idx];
  end

  // ==========================================================================
  // Sequencer: start, branching, recall
  always_comb begin
    state_d  = state_q;
    load_go  = 1'b0;
    load_set = sel_q;
    unique case (state_q)
      ST_IDLE: begin
        if (run_q) begin
          state_d  = ST_RUN;
          load_go  = 1'b1;
          load_set = init_q;
        end else if (recall_go) begin
          load_go = 1'b1;
        end
      end
      ST_RUN: begin
        // branch on path hits while on
        if (!run_q) begin
          state_d = ST_IDLE;
          load_go = recall_go;
        end else if (any_hit) begin
          load_go  = 1'b1;
          load_set = win_tgt;
        end else if (recall_go) begin
          load_go = 1'b1;
        end
      end
    endcase
  end

  // ==========================================================================
  // Register file and active values
  always_comb begin
    run_d    = run_q;
    edit_d   = edit_q;
    sel_d    = sel_q;
    init_d   = init_q;
    bsel_d   = bsel_q;
    fsel_d   = fsel_q;
    tgt_d    = tgt_q;
    org_d    = org_q;
    edg_d    = edg_q;
    act_d    = act_q;
    cur_d    = cur_q;
    loaded_d = load_go;
    if (wr_en) begin
      unique case (I_PADDR)
        ADDR_CTRL: begin
          run_d  = wmerged[CTRL_RUN_BIT];
          edit_d = wmerged[CTRL_EDIT_BIT];
        end
        ADDR_SET_SEL:
          if (wmerged < DATA_W'(NUM_SETS)) sel_d = wmerged[SET_W-1:0];
        ADDR_INIT_SET:
          if (wmerged < DATA_W'(NUM_SETS)) init_d = wmerged[SET_W-1:0];
        ADDR_BRANCH_SEL:
          if (wmerged < DATA_W'(NUM_PATHS)) bsel_d = wmerged[PATH_W-1:0];
        ADDR_FEAT_SEL:
          if (wmerged < DATA_W'(NUM_FEAT)) fsel_d = wmerged[FSEL_W-1:0];
        ADDR_BRANCH_CFG:
          if (edit_q) begin
            tgt_d[sel_q][bsel_q] = wmerged[CFG_TGT_LSB +: SET_W];
            org_d[sel_q][bsel_q] = wmerged[CFG_ORG_LSB +: ORIGIN_W];
            edg_d[sel_q][bsel_q] = trig_edge_t'(wmerged[CFG_EDGE_LSB +: 2]);
          end
        ADDR_FEAT_VAL:
          act_d[fsel_q*FEAT_W +: FEAT_W] = wmerged[FEAT_W-1:0];
        default: ;
      endcase
    end
    // whole set lands in one cycle
    if (load_go) begin
      for (int f = 0; f < NUM_FEAT; f++) begin
        if (MEMBER_MASK[f]) begin
          act_d[f*FEAT_W +: FEAT_W] = bank_rd[f*FEAT_W +: FEAT_W];
        end
      end
      cur_d = load_set;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_q  <= ST_IDLE;
      run_q    <= 1'b0;
      edit_q   <= 1'b0;
      loaded_q <= 1'b0;
      sel_q    <= '0;
      init_q   <= '0;
      cur_q    <= '0;
      bsel_q   <= '0;
      fsel_q   <= '0;
      act_q    <= '0;
      prdata_q <= '0;
      for (int s = 0; s < NUM_SETS; s++) begin
        for (int p = 0; p < NUM_PATHS; p++) begin
          tgt_q[s][p] <= '0;
          org_q[s][p] <= ORIGIN_OFF;
          edg_q[s][p] <= EDGE_RISE;
        end
      end
    end else begin
      state_q  <= state_d;
      run_q    <= run_d;
      edit_q   <= edit_d;
      loaded_q <= loaded_d;
      sel_q    <= sel_d;
      init_q   <= init_d;
      cur_q    <= cur_d;
      bsel_q   <= bsel_d;
      fsel_q   <= fsel_d;
      act_q    <= act_d;
      prdata_q <= prdata_d;
      tgt_q    <= tgt_d;
      org_q    <= org_d;
      edg_q    <= edg_d;
    end
  end

  // ==========================================================================
  // Outputs
  // load pulse marks the frame boundary for tagging
  assign O_PRDATA     = prdata_q;
  assign O_PREADY     = 1'b1;
  assign O_PSLVERR    = I_PSEL & I_PENABLE & ~addr_ok;
  assign O_FEAT_VAL   = act_q;
  assign O_CUR_SET    = cur_q;
  assign O_RUNNING    = (state_q == ST_RUN);
  assign O_SET_LOADED = loaded_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence start_seq;
    (state_q == ST_IDLE) && run_q;
  endsequence

  idle_quiet_a: assert property (!run_q && !recall_go |=> !loaded_q)
    else $error("set loaded while switching is off");
  start_load_a: assert property (start_seq |=> loaded_q && cur_q == $past(init_q))
    else $error("start did not load the initial set");
  cur_track_a: assert property (load_go |=> O_CUR_SET == $past(load_set) ##0 loaded_q)
    else $error("current index not updated on load");
  branch_take_a: assert property ((state_q == ST_RUN) && run_q && any_hit
                                  |=> cur_q == $past(win_tgt))
    else $error("trigger did not move to the path target");
  first_path_a: assert property (hit[0] |-> win_idx == '0)
    else $error("lowest firing path not chosen");
  feat_copy_a: assert property (load_go && MEMBER_MASK[0]
                                |=> O_FEAT_VAL[FEAT_W-1:0] == $past(bank_rd[FEAT_W-1:0]))
    else $error("member value not copied on load");
  sel_range_a: assert property ({1'b0, sel_q} < (SET_W+1)'(NUM_SETS) &&
                                {1'b0, init_q} < (SET_W+1)'(NUM_SETS))
    else $error("set index out of range");
  store_gate_a: assert property (wr_en && (I_PADDR == ADDR_CMD) && !edit_q |-> !store_go)
    else $error("store accepted outside edit mode");
  off_path_a: assert property (org_q[cur_q][0] == ORIGIN_OFF |-> !hit[0])
    else $error("path with origin off fired");

endmodule

// [rtl/set_bank.sv]
/*
  Flip-flop storage for the stored settings sets.
  Assumes one write port and a combinational read of a whole set.
*/
`timescale 1ns/1ps
module set_bank #(
  parameter int NUM_SETS = 4,
  parameter int NUM_FEAT = 4,
  parameter int FEAT_W   = 16,
  parameter int SET_W    = 2
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // Write port
  input  wire logic                       i_wr,
  input  wire logic [SET_W-1:0]           i_wr_set,
  input  wire logic [NUM_FEAT-1:0]        i_wr_mask,
  input  wire logic [NUM_FEAT*FEAT_W-1:0] i_wr_data,
  // Read port
  input  wire logic [SET_W-1:0]           i_rd_set,
  output logic      [NUM_FEAT*FEAT_W-1:0] o_rd_data
);

  logic [NUM_FEAT*FEAT_W-1:0] mem_q [NUM_SETS];
  logic [NUM_FEAT*FEAT_W-1:0] mem_d [NUM_SETS];

  // ==========================================================================
  // One entry per set; only member features are overwritten
  for (genvar s = 0; s < NUM_SETS; s++) begin : g_set
    always_comb begin
      mem_d[s] = mem_q[s];
      for (int f = 0; f < NUM_FEAT; f++) begin
        if (i_wr && (i_wr_set == SET_W'(s)) && i_wr_mask[f]) begin
          mem_d[s][f*FEAT_W +: FEAT_W] = i_wr_data[f*FEAT_W +: FEAT_W];
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        mem_q[s] <= '0;
      end else begin
        mem_q[s] <= mem_d[s];
      end
    end
  end

  assign o_rd_data = mem_q[i_rd_set];

endmodule

// [rtl/trig_sense.sv]
/*
  Edge and level sensing of the trigger event inputs.
  Assumes the inputs may be asynchronous to the system clock.
*/
`timescale 1ns/1ps
module trig_sense #(
  parameter int NUM_EVT = 7
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Raw events
  input  wire logic [NUM_EVT-1:0] i_evt,
  // Filtered results, one cycle pulses for edges
  output logic      [NUM_EVT-1:0] o_rise,
  output logic      [NUM_EVT-1:0] o_fall,
  output logic      [NUM_EVT-1:0] o_lvl
);

  // ==========================================================================
  // Per event synchroniser and filter
  for (genvar g = 0; g < NUM_EVT; g++) begin : g_evt
    logic s1_q, s2_q, s3_q, lvl_q;
    logic s1_d, s2_d, s3_d, lvl_d;

    // Level only moves once the second and third stage agree
    always_comb begin
      s1_d  = i_evt[g];
      s2_d  = s1_q;
      s3_d  = s2_q;
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        s1_q  <= 1'b0;
        s2_q  <= 1'b0;
        s3_q  <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q  <= s1_d;
        s2_q  <= s2_d;
        s3_q  <= s3_d;
        lvl_q <= lvl_d;
      end
    end

    assign o_rise[g] = lvl_d & ~lvl_q;
    assign o_fall[g] = ~lvl_d & lvl_q;
    assign o_lvl[g]  = lvl_q;
  end

endmodule

// [shared/seq_pkg.sv]
/*
  Constants, register map and types shared by the parameter-set sequencer.
  Assumes a 32-bit APB slave port with byte addresses in the low eight bits.
*/
package seq_pkg;

  // ==========================================================================
  // Default sizes
  localparam int NUM_SETS_DEF  = 4;
  localparam int NUM_PATHS_DEF = 2;
  localparam int NUM_FEAT_DEF  = 4;
  localparam int FEAT_W_DEF    = 16;
  localparam int NUM_EVT_DEF   = 7;
  localparam int ORIGIN_W      = 3;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // ==========================================================================
  // Trigger origin and activation
  localparam logic [ORIGIN_W-1:0] ORIGIN_OFF = 3'h0;

  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_ANY,
    EDGE_HIGH
  } trig_edge_t;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SET_SEL    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INIT_SET   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CMD        = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_BRANCH_SEL = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_BRANCH_CFG = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_FEAT_SEL   = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_FEAT_ON    = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_FEAT_VAL   = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_EDIT_BIT  = 1;
  localparam int CMD_STORE_BIT  = 0;
  localparam int CMD_RECALL_BIT = 1;
  localparam int STAT_RUN_BIT   = 8;
  localparam int CFG_TGT_LSB    = 0;
  localparam int CFG_ORG_LSB    = 4;
  localparam int CFG_EDGE_LSB   = 8;

endpackage

// [tb/evt_src.sv]
/*
  Trigger event source standing in for the event lines around the sequencer.
  Assumes requests arrive as one-cycle pulses in the system clock domain.
*/
`timescale 1ns/1ps
module evt_src (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Request, one bit per line
  input  wire logic [6:0] i_req,
  // Event lines, idle low
  output logic      [6:0] o_evt
);
  // ==========================================================================
  // Pulse shaping
  logic [3:0] cnt_q;

  // Eight cycles high, so rise and fall are far apart for edge tests
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_evt <= 7'h00;
      cnt_q <= 4'h0;
    end else if (i_req != 7'h00) begin
      o_evt <= i_req;
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        o_evt <= 7'h00;
      end
    end
  end
endmodule

// [tb/test_parameter_set_sequencer.sv]
/*
  Self-checking bench for the parameter-set sequencer.
  Assumes zero-wait APB and the register map of seq_pkg.
*/
`timescale 1ns/1ps
module test_parameter_set_sequencer;
  import seq_pkg::*;
  // ==========================================================================
  // Signals
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [6:0]  req     = 7'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        running;
  logic        loaded;
  logic        last_err;
  logic [6:0]  evt;
  logic [63:0] feat;
  logic [1:0]  cur;
  int          last_n;
  int          num_errors = 0;
  int          compares   = 0;

  // 125 MHz system clock
  always #4 sys_clk = ~sys_clk;

  seq_top DUT (
    .I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hf),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TRIG_EVENTS(evt),
    .O_FEAT_VAL(feat), .O_CUR_SET(cur), .O_RUNNING(running), .O_SET_LOADED(loaded));

  evt_src partner (.i_clk(sys_clk), .i_rst(sys_rst), .i_req(req), .o_evt(evt));

  // ==========================================================================
  // Helpers
  task end_sim;
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge sys_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'h1) break;
    end
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (i == 20) begin
      num_errors++;
      end_sim();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'h0, a, 32'h0, r);
  endtask

  function automatic logic [15:0] fv(input int s, input int f);
    fv = {4'(s), 4'(f), 8'ha5};
  endfunction

  function automatic logic [63:0] expv(input int s);
    for (int f = 0; f < 4; f++) expv[f*16+:16] = fv(s, f);
  endfunction

  function automatic logic [31:0] cfg(input logic [1:0] t, input logic [2:0] o,
                                      input trig_edge_t e);
    cfg = {22'h0, e, 1'h0, o, 2'h0, t};
  endfunction

  // Bounded wait for the load pulse; 30 means none came. First look is just
  // after the edge the caller returned on, so a pulse launched there counts.
  task wait_load;
    for (last_n = 0; last_n < 30; last_n++) begin
      #1;
      if (loaded === 1'h1) break;
      @(posedge sys_clk);
    end
  endtask

  // Spacing lets the previous event pulse die out first
  task step(input logic [6:0] bits, input int s, input logic exp_load);
    repeat (10) @(posedge sys_clk);
    req <= bits;
    @(posedge sys_clk);
    req <= 7'h00;
    wait_load();
    chk("load seen", exp_load, last_n < 30);
    if (exp_load) begin
      chk("current set", s, cur);
      chk("feature values", expv(s), feat);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task t_reset;
    logic [31:0] r;
    chk("outputs at reset", 0, {loaded, running, cur});
    rd(ADDR_STATUS, r);
    chk("status at reset", 0, r);
    rd(ADDR_CTRL, r);
    chk("ctrl at reset", 0, r);
    rd(8'h80, r);
    chk("unmapped error", 1, last_err);
  endtask

  task t_store;
    logic [31:0] r;
    wr(ADDR_CTRL, 32'h2);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_SET_SEL, 32'(s));
      for (int f = 0; f < 4; f++) begin
        wr(ADDR_FEAT_SEL, 32'(f));
        wr(ADDR_FEAT_VAL, {16'h0, fv(s, f)});
        rd(ADDR_FEAT_ON, r);
        chk("member flag", 1, r[0]);
      end
      wr(ADDR_CMD, 32'h1);
    end
  endtask

  task t_recall(input int s);
    logic [31:0] r;
    wr(ADDR_SET_SEL, 32'(s));
    wr(ADDR_CMD, 32'h2);
    wait_load();
    chk("recall pulse", 1, last_n < 30);
    chk("recall values", expv(s), feat);
    chk("recall index", s, cur);
    wr(ADDR_FEAT_SEL, 32'h1);
    rd(ADDR_FEAT_VAL, r);
    chk("readback", fv(s, 1), r);
  endtask

  task t_refuse;
    logic [31:0] r;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SET_SEL, 32'h1);
    wr(ADDR_FEAT_SEL, 32'h0);
    wr(ADDR_FEAT_VAL, 32'hdead);
    wr(ADDR_CMD, 32'h1);
    wr(ADDR_SET_SEL, 32'h4);
    rd(ADDR_SET_SEL, r);
    chk("selector range", 1, r);
    wr(ADDR_INIT_SET, 32'h3);
    wr(ADDR_INIT_SET, 32'h4);
    rd(ADDR_INIT_SET, r);
    chk("initial range", 3, r);
    wr(ADDR_INIT_SET, 32'h0);
    t_recall(1);
  endtask

  task path(input int s, input int p, input logic [31:0] c);
    wr(ADDR_SET_SEL, 32'(s));
    wr(ADDR_BRANCH_SEL, 32'(p));
    wr(ADDR_BRANCH_CFG, c);
  endtask

  // Host gives every used path a target, origin and activation
  task t_paths;
    wr(ADDR_CTRL, 32'h2);
    path(0, 0, cfg(2'h1, 3'h1, EDGE_RISE));
    path(0, 1, cfg(2'h3, 3'h2, EDGE_RISE));
    path(1, 0, cfg(2'h0, 3'h3, EDGE_FALL));
    path(1, 1, cfg(2'h2, 3'h4, EDGE_RISE));
    path(2, 0, cfg(2'h1, 3'h4, EDGE_ANY));
    path(3, 0, cfg(2'h3, 3'h2, EDGE_RISE));
    path(3, 1, cfg(2'h1, ORIGIN_OFF, EDGE_RISE));
  endtask

  task t_run;
    logic [31:0] r;
    wr(ADDR_CTRL, 32'h1);
    wait_load();
    chk("start load", 1, last_n < 30);
    chk("start set", 0, cur);
    chk("start values", expv(0), feat);
    chk("running", 1, running);
    step(7'h01, 1, 1'h1);
    step(7'h04, 0, 1'h1);
    chk("falling edge late", 1, last_n > 8);
    step(7'h03, 1, 1'h1);
    step(7'h08, 2, 1'h1);
    @(posedge sys_clk);
    wait_load();
    chk("any edge fall", 1, cur);
    step(7'h04, 0, 1'h1);
    step(7'h02, 3, 1'h1);
    step(7'h02, 3, 1'h1);
    step(7'h01, 3, 1'h0);
    rd(ADDR_STATUS, r);
    chk("status running", 32'h103, r);
    wr(ADDR_CTRL, 32'h0);
    step(7'h02, 3, 1'h0);
    chk("stopped", 0, running);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_store();
    t_recall(2);
    t_refuse();
    t_paths();
    t_run();
    end_sim();
  end
endmodule
